// >>> common/stdp_pkg.sv
// Constants, register map and carrier types of the software trace debug port.
// Assumes a 50 MHz core clock and a classic Wishbone slave with 32-bit data.
package stdp_pkg;
    localparam int CLK_MHZ = 50;
    localparam int LONG_REC_NS = 1727;
    localparam int SHORT_REC_NS = 576;
    localparam int LONG_REC_CYC = LONG_REC_NS * CLK_MHZ / 1000;
    localparam int SHORT_REC_CYC = SHORT_REC_NS * CLK_MHZ / 1000;
    localparam int TRACE_DEPTH = 8;
    localparam int REC_BITS = 72;
    localparam int SHORT_BITS = 40;

    localparam logic [7:0] ADR_OPT_ZERO = 8'h00;
    localparam logic [7:0] ADR_OPT_TWO = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    localparam logic [7:0] ADR_CTRL = 8'h10;
    localparam logic [7:0] ADR_LEVEL = 8'h14;

    localparam int SEL_HI_POS = 30;
    localparam int SEL_LO_POS = 29;
    localparam int MODE_SEL_POS = 1;
    localparam logic [1:0] IF_LPD = 2'h1;
    localparam logic [1:0] IF_JTAG = 2'h3;
    localparam logic [31:0] OPT_TWO_RST = 32'h6000_0000;
    localparam logic [31:0] OPT_ZERO_RST = 32'h0000_0002;

    localparam int ST_OVF = 0;
    localparam int ST_SENT = 1;
    localparam int ST_CLR = 2;
    localparam int ST_W = 3;
    localparam int CTRL_EN = 0;

    typedef enum logic [1:0] {
        STDP_K_PC = 2'h0,
        STDP_K_TAG = 2'h1,
        STDP_K_REG = 2'h2,
        STDP_K_OVF = 2'h3
    } stdp_kind_t;

    typedef struct packed {
        stdp_kind_t kind;
        logic with_pc;
        logic [4:0] reg_num;
        logic [31:0] value;
        logic [31:0] pc;
    } stdp_rec_t;

    typedef struct packed {
        logic valid;
        stdp_kind_t op;
        logic with_pc;
        logic [31:0] pc;
        logic [9:0] tag_immediate;
        logic [4:0] reg_lo;
        logic [4:0] reg_hi;
    } stdp_instr_t;
endpackage

// >>> hdl/stdp_trace_port.sv
// Software trace port: trace buffer, link serializer, option bytes, RAM clear.
// Assumes the core holds i_instr until o_instr_ready and reads GPRs combinationally.
`timescale 1ns/1ps
module stdp_trace_port #(
    parameter int DEPTH = stdp_pkg::TRACE_DEPTH,
    parameter int RAM_AW = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    input wire stdp_pkg::stdp_instr_t i_instr,
    output logic o_instr_ready,
    output logic [4:0] o_gpr_addr,
    input wire logic [31:0] i_gpr_data,
    input wire logic i_emu_connected,
    output logic o_link_dat,
    output logic o_link_frame,
    output logic [1:0] o_ram_area,
    output logic [RAM_AW-1:0] o_ram_addr,
    output logic o_ram_we,
    output logic [31:0] o_ram_wdata
);
    typedef enum logic [1:0] {S_IDLE = 2'b01, S_DUMP = 2'b10} stdp_dump_t;
    typedef enum logic [2:0] {C_IDLE = 3'b001, C_RUN = 3'b010, C_DONE = 3'b100} stdp_clr_t;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int PW = $clog2(DEPTH);
    localparam logic [CW-1:0] LAST_FREE = CW'(DEPTH - 1);
    // One bit per core clock cannot fit a short record into its link time, so it is stretched.
    localparam int SHORT_DUR = (stdp_pkg::SHORT_REC_CYC > stdp_pkg::SHORT_BITS) ?
                               stdp_pkg::SHORT_REC_CYC : stdp_pkg::SHORT_BITS;
    localparam logic [1:0] AREAS = 2'h3;

    stdp_dump_t dump_state;
    stdp_clr_t clr_state;
    logic [4:0] dump_reg;
    logic dump_pc;
    logic [31:0] dump_pcv;
    logic [4:0] dump_hi;
    stdp_pkg::stdp_rec_t mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic rec_valid;
    stdp_pkg::stdp_rec_t rec;
    logic push;
    logic pop;
    stdp_pkg::stdp_rec_t push_rec;
    logic ovf_event;
    logic sent_event;
    logic clr_event;
    logic [stdp_pkg::REC_BITS-1:0] shift;
    logic [7:0] bit_cnt;
    logic [7:0] bit_len;
    logic [7:0] dur_len;
    logic link_busy;
    logic conn_q;
    logic [31:0] opt_zero;
    logic [31:0] opt_two;
    logic [stdp_pkg::ST_W-1:0] status;
    logic [stdp_pkg::ST_W-1:0] mask;
    logic [31:0] ctrl;
    logic wb_req;
    logic wb_wr;

    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Trace is accepted only with an emulator attached and tracing enabled.
    logic trace_on;
    assign trace_on = i_emu_connected & ctrl[stdp_pkg::CTRL_EN];

    // Register dump walks one register per cycle; the core is stalled meanwhile.
    assign o_instr_ready = (dump_state == S_IDLE);
    assign o_gpr_addr = (dump_state == S_DUMP) ? dump_reg : i_instr.reg_lo;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            dump_state <= S_IDLE;
            dump_reg <= 5'h00;
            dump_hi <= 5'h00;
            dump_pc <= 1'b0;
            dump_pcv <= 32'h0000_0000;
        end else begin
            case (dump_state)
                S_IDLE: begin
                    if (i_instr.valid && i_instr.op == stdp_pkg::STDP_K_REG &&
                        i_instr.reg_hi > i_instr.reg_lo) begin
                        dump_state <= S_DUMP;
                        dump_reg <= i_instr.reg_lo + 5'h01;
                        dump_hi <= i_instr.reg_hi;
                        dump_pc <= i_instr.with_pc;
                        dump_pcv <= i_instr.pc;
                    end
                end
                S_DUMP: begin
                    dump_reg <= dump_reg + 5'h01;
                    if (dump_reg == dump_hi) begin
                        dump_state <= S_IDLE;
                    end
                end
                default: dump_state <= S_IDLE;
            endcase
        end
    end

    always_comb begin
        rec_valid = 1'b0;
        rec = '0;
        if (dump_state == S_DUMP) begin
            rec_valid = 1'b1;
            rec.kind = stdp_pkg::STDP_K_REG;
            rec.with_pc = dump_pc;
            rec.reg_num = dump_reg;
            rec.value = i_gpr_data;
            rec.pc = dump_pcv;
        end else if (i_instr.valid) begin
            rec_valid = 1'b1;
            rec.kind = i_instr.op;
            rec.pc = i_instr.pc;
            case (i_instr.op)
                stdp_pkg::STDP_K_PC: rec.with_pc = 1'b1;
                stdp_pkg::STDP_K_TAG: begin
                    rec.with_pc = i_instr.with_pc;
                    rec.value = {22'h000000, i_instr.tag_immediate};
                end
                stdp_pkg::STDP_K_REG: begin
                    rec.with_pc = i_instr.with_pc;
                    rec.reg_num = i_instr.reg_lo;
                    rec.value = i_gpr_data;
                end
                default: rec_valid = 1'b0;
            endcase
        end
    end

    // Seven stages take records; the eighth only ever holds the overflow marker.
    always_comb begin
        push = 1'b0;
        ovf_event = 1'b0;
        push_rec = rec;
        if (rec_valid && trace_on) begin
            if (count < LAST_FREE) begin
                push = 1'b1;
            end else if (count == LAST_FREE) begin
                push = 1'b1;
                ovf_event = 1'b1;
                push_rec = '0;
                push_rec.kind = stdp_pkg::STDP_K_OVF;
            end else begin
                ovf_event = 1'b1;
            end
        end
    end

    assign pop = ~link_busy & (count != '0) & i_emu_connected;

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= push_rec;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + PW'(push);
            rd_ptr <= rd_ptr + PW'(pop);
            count <= count + CW'(push) - CW'(pop);
        end
    end

    // One record per frame; the frame lasts bit_len cycles and the link stays busy for dur_len cycles.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            link_busy <= 1'b0;
            shift <= '0;
            bit_cnt <= 8'h00;
            bit_len <= 8'h00;
            dur_len <= 8'h00;
        end else if (pop) begin
            link_busy <= 1'b1;
            shift <= mem[rd_ptr];
            bit_cnt <= 8'h00;
            bit_len <= mem[rd_ptr].with_pc ? 8'(stdp_pkg::REC_BITS) : 8'(stdp_pkg::SHORT_BITS);
            dur_len <= (mem[rd_ptr].with_pc || mem[rd_ptr].kind == stdp_pkg::STDP_K_REG) ?
                       8'(stdp_pkg::LONG_REC_CYC) : 8'(SHORT_DUR);
        end else if (link_busy) begin
            shift <= {shift[stdp_pkg::REC_BITS-2:0], 1'b0};
            bit_cnt <= bit_cnt + 8'h01;
            if (bit_cnt == dur_len - 8'h01) begin
                link_busy <= 1'b0;
            end
        end
    end

    assign sent_event = link_busy & (bit_cnt == dur_len - 8'h01);
    assign o_link_frame = link_busy & (bit_cnt < bit_len) & i_emu_connected;
    assign o_link_dat = o_link_frame & shift[stdp_pkg::REC_BITS-1];

    // RAM clear runs over every area once per new connection.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            conn_q <= 1'b0;
            clr_state <= C_IDLE;
            o_ram_area <= 2'h0;
            o_ram_addr <= '0;
        end else begin
            conn_q <= i_emu_connected;
            case (clr_state)
                C_IDLE: begin
                    if (i_emu_connected && !conn_q) begin
                        clr_state <= C_RUN;
                        o_ram_area <= 2'h0;
                        o_ram_addr <= '0;
                    end
                end
                C_RUN: begin
                    o_ram_addr <= o_ram_addr + RAM_AW'(1);
                    if (&o_ram_addr) begin
                        o_ram_area <= o_ram_area + 2'h1;
                        if (o_ram_area == AREAS - 2'h1) begin
                            clr_state <= C_DONE;
                        end
                    end
                end
                C_DONE: clr_state <= C_IDLE;
                default: clr_state <= C_IDLE;
            endcase
        end
    end

    assign o_ram_we = (clr_state == C_RUN);
    assign o_ram_wdata = 32'h0000_0000;
    assign clr_event = (clr_state == C_DONE);

    assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wb_wr = wb_req & i_wb_we;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= wb_req;
            case (i_wb_adr)
                stdp_pkg::ADR_OPT_ZERO: begin
                    o_wb_dat <= opt_zero;
                    if (i_emu_connected) begin
                        o_wb_dat[stdp_pkg::MODE_SEL_POS] <= 1'b0;
                    end
                end
                stdp_pkg::ADR_OPT_TWO: o_wb_dat <= opt_two;
                stdp_pkg::ADR_STATUS: o_wb_dat <= 32'(status);
                stdp_pkg::ADR_MASK: o_wb_dat <= 32'(mask);
                stdp_pkg::ADR_CTRL: o_wb_dat <= ctrl;
                stdp_pkg::ADR_LEVEL: o_wb_dat <= 32'(count);
                default: o_wb_dat <= 32'h0000_0000;
            endcase
        end
    end

    // The emulator owns the interface select field, so bus writes never reach it.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            opt_zero <= stdp_pkg::OPT_ZERO_RST;
            opt_two <= stdp_pkg::OPT_TWO_RST;
        end else begin
            if (wb_wr && i_wb_adr == stdp_pkg::ADR_OPT_ZERO) begin
                opt_zero <= wb_merge(opt_zero, i_wb_dat, i_wb_sel);
            end
            if (wb_wr && i_wb_adr == stdp_pkg::ADR_OPT_TWO) begin
                opt_two <= wb_merge(opt_two, i_wb_dat, i_wb_sel);
                opt_two[stdp_pkg::SEL_HI_POS:stdp_pkg::SEL_LO_POS] <=
                    opt_two[stdp_pkg::SEL_HI_POS:stdp_pkg::SEL_LO_POS];
            end else if (i_emu_connected) begin
                opt_two[stdp_pkg::SEL_HI_POS:stdp_pkg::SEL_LO_POS] <= stdp_pkg::IF_LPD;
            end
        end
    end

    logic [31:0] mask_merged;
    assign mask_merged = wb_merge(32'(mask), i_wb_dat, i_wb_sel);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            mask <= '0;
            ctrl <= 32'h0000_0001;
        end else begin
            if (wb_wr && i_wb_adr == stdp_pkg::ADR_MASK) begin
                mask <= mask_merged[stdp_pkg::ST_W-1:0];
            end
            if (wb_wr && i_wb_adr == stdp_pkg::ADR_CTRL) begin
                ctrl <= wb_merge(ctrl, i_wb_dat, i_wb_sel);
            end
        end
    end

    // A new event in the clearing cycle wins over the write-one-to-clear.
    logic [stdp_pkg::ST_W-1:0] events;
    logic [stdp_pkg::ST_W-1:0] w1c;
    assign events = {clr_event, sent_event, ovf_event};
    assign w1c = (wb_wr && i_wb_adr == stdp_pkg::ADR_STATUS && i_wb_sel[0]) ?
                 i_wb_dat[stdp_pkg::ST_W-1:0] : '0;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status <= '0;
        end else begin
            status <= (status & ~w1c) | events;
        end
    end

    assign o_irq = |(status & mask);
endmodule // stdp_trace_port

// >>> verification/stdp_trace_port_properties.sv
// Concurrent checks on the pins of the software trace port.
// Assumes one core clock and the synchronous active-high reset of the top module.
`timescale 1ns/1ps
module stdp_trace_port_properties #(
    parameter int RAM_AW = 12
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    input wire stdp_pkg::stdp_instr_t i_instr,
    input wire logic o_instr_ready,
    input wire logic [4:0] o_gpr_addr,
    input wire logic i_emu_connected,
    input wire logic o_link_frame,
    input wire logic o_ram_we,
    input wire logic [31:0] o_ram_wdata
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    int frame_len;
    int clear_len;
    always_ff @(posedge i_core_clk) begin
        frame_len <= (o_link_frame && !i_rst) ? frame_len + 1 : 0;
        clear_len <= (o_ram_we && !i_rst) ? clear_len + 1 : 0;
    end
    sequence s_wb_req;
        i_wb_cyc && i_wb_stb && !o_wb_ack;
    endsequence
    sequence s_dump_start;
        i_instr.valid && o_instr_ready && i_emu_connected &&
            i_instr.op == stdp_pkg::STDP_K_REG && i_instr.reg_hi > i_instr.reg_lo;
    endsequence
    a_ack_next: assert property (s_wb_req |=> o_wb_ack) else $error("ack late");
    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
    a_dump_stall: assert property (s_dump_start |=> !o_instr_ready) else $error("no stall");
    a_dump_bound: assert property (s_dump_start |-> ##[1:32] o_instr_ready)
        else $error("dump never ends");
    a_dump_ascend: assert property (!o_instr_ready && $past(!o_instr_ready) |->
        o_gpr_addr == $past(o_gpr_addr) + 5'h1) else $error("register order wrong");
    a_frame_len: assert property ($fell(o_link_frame) |->
        frame_len == stdp_pkg::SHORT_BITS || frame_len == stdp_pkg::REC_BITS)
        else $error("frame length wrong");
    a_quiet_link: assert property (!i_emu_connected |-> !o_link_frame)
        else $error("link active without emulator");
    a_clear_start: assert property ($rose(i_emu_connected) |-> ##[1:2] o_ram_we)
        else $error("ram clear missing");
    a_clear_len: assert property ($fell(o_ram_we) |-> clear_len == 3 * (1 << RAM_AW))
        else $error("ram clear length wrong");
    a_clear_zero: assert property (o_ram_we |-> o_ram_wdata == 32'h0)
        else $error("ram clear data not zero");
endmodule // stdp_trace_port_properties

bind stdp_trace_port stdp_trace_port_properties #(.RAM_AW(RAM_AW)) u_props (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .i_instr(i_instr), .o_instr_ready(o_instr_ready),
    .o_gpr_addr(o_gpr_addr), .i_emu_connected(i_emu_connected),
    .o_link_frame(o_link_frame), .o_ram_we(o_ram_we), .o_ram_wdata(o_ram_wdata));

// >>> verification/stdp_emu_probe.sv
// Emulator probe model: collects trace records from the serial link.
// Assumes one data bit per core clock, MSB first, while the frame line is high.
`timescale 1ns/1ps
module stdp_emu_probe (
    input wire logic i_core_clk,
    input wire logic i_link_frame,
    input wire logic i_link_dat
);
    logic [71:0] shift_reg = 72'h0;
    int bit_cnt = 0;
    logic [71:0] rx_q[$];
    // Records are left-aligned so that short and long frames compare alike.
    always @(posedge i_core_clk) begin
        if (i_link_frame) begin
            shift_reg <= {shift_reg[70:0], i_link_dat};
            bit_cnt <= bit_cnt + 1;
        end else if (bit_cnt != 0) begin
            rx_q.push_back(shift_reg << (72 - bit_cnt));
            bit_cnt <= 0;
        end
    end
endmodule // stdp_emu_probe

// >>> verification/stdp_trace_port_bench.sv
// Self-checking bench for the trace port with an emulator probe on the link.
// Assumes a 50 MHz clock and a shortened RAM clear through RAM_AW.
`timescale 1ns/1ps
module stdp_trace_port_bench;
    localparam int AW = 2;
    logic clk, rst, cyc, stb, we, conn, link_dat, frame, ack, irq, ready, ram_we;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, gpr_data, ram_wdata, q;
    logic [4:0] gpr_addr;
    logic [1:0] ram_area;
    logic [AW-1:0] ram_addr;
    stdp_pkg::stdp_instr_t instr;
    stdp_pkg::stdp_instr_t ins_a[4];
    logic [31:0] gpr[32];
    logic [71:0] exp_q[$];
    logic [71:0] msk_q[$];
    int miscompares = 0;
    int comparisons = 0;
    int seed = 32'h61921e75;
    // Register file answers combinationally, as the core would.
    assign gpr_data = gpr[gpr_addr];
    stdp_trace_port #(.RAM_AW(AW)) dut (.i_core_clk(clk), .i_rst(rst), .i_wb_adr(adr),
        .i_wb_dat(wdat), .i_wb_sel(4'hf), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .i_instr(instr),
        .o_instr_ready(ready), .o_gpr_addr(gpr_addr), .i_gpr_data(gpr_data),
        .i_emu_connected(conn), .o_link_dat(link_dat), .o_link_frame(frame),
        .o_ram_area(ram_area), .o_ram_addr(ram_addr), .o_ram_we(ram_we),
        .o_ram_wdata(ram_wdata));
    stdp_emu_probe probe (.i_core_clk(clk), .i_link_frame(frame), .i_link_dat(link_dat));
    int ram_writes = 0;
    int ram_order_bad = 0;
    // The clear walks every word of each area in turn, so area and address form one count.
    always @(posedge clk) begin
        if (ram_we === 1'b1) begin
            if ({ram_area, ram_addr} !== (2 + AW)'(ram_writes)) ram_order_bad <= ram_order_bad + 1;
            ram_writes <= ram_writes + 1;
        end
    end
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task stop_test;
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string name, input logic [71:0] e, input logic [71:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        wb(a, 1'b0, 32'h0);
        chk($sformatf("register %h", a), 72'(e & m), 72'(q & m));
    endtask
    function logic [71:0] rec(logic [1:0] k, logic p, logic [4:0] r, logic [31:0] v,
        logic [31:0] pc);
        return {k, p, r, v, pc};
    endfunction
    function logic [71:0] msk(logic r, logic v, logic p);
        return rec(2'h3, 1'b1, {5{r}}, {32{v}}, {32{p}});
    endfunction
    function stdp_pkg::stdp_instr_t mk(logic [1:0] op, logic wp, logic [31:0] pc,
        logic [9:0] imm, logic [4:0] lo, logic [4:0] hi);
        return '{1'b1, stdp_pkg::stdp_kind_t'(op), wp, pc, imm, lo, hi};
    endfunction
    task add(input logic [71:0] e, input logic [71:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
    endtask
    task expect_rec(input stdp_pkg::stdp_instr_t s);
        int r;
        if (s.op == stdp_pkg::STDP_K_PC) add(rec(2'h0, 1'b1, 5'h0, 32'h0, s.pc),
            msk(0, 0, 1));
        else if (s.op == stdp_pkg::STDP_K_TAG) add(rec(2'h1, s.with_pc, 5'h0,
            {22'h0, s.tag_immediate}, s.pc), msk(0, 1, s.with_pc));
        else for (r = s.reg_lo; r <= s.reg_hi || r == s.reg_lo; r++)
            add(rec(2'h2, s.with_pc, 5'(r), gpr[r], s.pc), msk(1, 1, s.with_pc));
    endtask
    task issue(input stdp_pkg::stdp_instr_t s);
        instr <= s;
        do @(posedge clk); while (ready !== 1'b1);
    endtask
    task go(input int n);
        int k;
        logic [71:0] e;
        logic [71:0] m;
        for (k = 0; k < n; k++) begin
            issue(ins_a[k]);
            expect_rec(ins_a[k]);
        end
        instr <= '0;
        for (k = 0; k < 3000 && probe.rx_q.size() < exp_q.size(); k++) @(posedge clk);
        repeat (100) @(posedge clk);
        chk("record count", 72'(exp_q.size()), 72'(probe.rx_q.size()));
        while (exp_q.size() != 0 && probe.rx_q.size() != 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            chk("record", e & m, probe.rx_q.pop_front() & m);
        end
        exp_q.delete();
        msk_q.delete();
        probe.rx_q.delete();
    endtask
    task quiet_check;
        issue(mk(2'h0, 1'b1, 32'h1234, 10'h0, 5'h0, 5'h0));
        instr <= '0;
        repeat (200) @(posedge clk);
        chk("quiet link", 72'h0, 72'(probe.rx_q.size()));
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        stop_test;
    end
    initial begin
        int k;
        int n;
        logic [31:0] r;
        logic [7:0] ra[7];
        logic [31:0] rv[7];
        {rst, cyc, stb, we, conn, adr, wdat} = {1'b1, 44'h0};
        ra = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h3c};
        rv = '{32'h2, 32'h6000_0000, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
        instr = '0;
        for (k = 0; k < 32; k++) gpr[k] = $random(seed);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 7; k++) rd(ra[k], rv[k], 32'hffff_ffff);
        quiet_check;
        $display("Test reset and quiet done");
        conn <= 1'b1;
        k = 0;
        do begin
            wb(8'h08, 1'b0, 32'h0);
            k++;
        end while (q[2] !== 1'b1 && k < 20);
        rd(8'h08, 32'h4, 32'h4);
        chk("ram clear writes", 72'(3 << AW), 72'(ram_writes));
        chk("ram clear order", 72'h0, 72'(ram_order_bad));
        rd(8'h00, 32'h0, 32'h2);
        wb(8'h04, 1'b1, 32'h2000_0055);
        rd(8'h04, 32'h2000_0055, 32'h6000_00ff);
        wb(8'h08, 1'b1, 32'hffff_ffff);
        $display("Test connection done");
        ins_a[0] = mk(2'h2, 1'b1, $random(seed), 10'h0, 5'h1c, 5'h1f);
        ins_a[1] = mk(2'h1, 1'b0, 32'h0, 10'h3ff, 5'h0, 5'h0);
        go(2);
        for (n = 0; n < 2; n++) begin
            ins_a[0] = mk(2'h0, 1'b1, $random(seed), 10'h0, 5'h0, 5'h0);
            ins_a[1] = mk(2'h1, 1'b1, $random(seed), 10'(n), 5'h0, 5'h0);
            for (k = 2; k < 4; k++) begin
                r = $random(seed);
                ins_a[k] = mk(r[6:5] == 2'h3 ? 2'h1 : r[6:5], r[7], $random(seed), r[17:8],
                    r[4:0] & 5'h1e, (r[4:0] & 5'h1e) + 5'(r[18]));
            end
            go(4);
        end
        $display("Test records done");
        @(negedge clk);
        chk("masked irq", 72'h0, 72'(irq));
        wb(8'h0c, 1'b1, 32'h2);
        @(negedge clk);
        chk("raised irq", 72'h1, 72'(irq));
        wb(8'h08, 1'b1, 32'h2);
        @(negedge clk);
        chk("cleared irq", 72'h0, 72'(irq));
        wb(8'h0c, 1'b1, 32'h0);
        $display("Test interrupt done");
        for (k = 0; k < 10; k++) issue(mk(2'h1, 1'b0, 32'h0, 10'h3f0 + 10'(k), 5'h0, 5'h0));
        instr <= '0;
        repeat (1500) @(posedge clk);
        n = probe.rx_q.size();
        chk("overflow count", 72'h1, 72'(n == 8 || n == 9));
        for (k = 0; k < n - 1; k++) chk("burst record", rec(2'h1, 1'b0, 5'h0, 32'h3f0 +
            32'(k), 32'h0) & msk(0, 1, 0), probe.rx_q[k] & msk(0, 1, 0));
        chk("overflow marker", 72'h3, 72'(probe.rx_q[n - 1][71:70]));
        rd(8'h08, 32'h1, 32'h1);
        probe.rx_q.delete();
        $display("Test overflow done");
        wb(8'h10, 1'b1, 32'h0);
        quiet_check;
        $display("Test disable done");
        stop_test;
    end
endmodule // stdp_trace_port_bench
